/* verilog/mpg_core.sv */
// motion pulse generator: one axis, APB registers, step/direction out
// assumes: one 125 MHz clock, all pins synchronous to it, APB master
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "mpg_cfg.svh"

// Function
// RL1: commanded counter counts up on every emitted step pulse.
// RL2: feedback counter follows quadrature encoder phases A and B.
// RL3: latch command copies both counters in the same cycle, motion continues.
// RL4: comparator sets a sticky flag when the chosen counter equals compare.
// RL5: acceleration and deceleration rates are separate registers, each own ramp.
// RL6: corrected top speed is a pure function of the mode, speed, acceleration and feed registers.
// RL7: registers change only on clock edges; a stopped clock stalls access.
// RL8: narrow accesses use little-endian byte lanes via write strobes.
// RL9: limit level clears the rate divider in the run state, over any command.
// RL10: limit clears run state, divider and pulse output stage.
// RL11: feed away from an active limit stays allowed.
// RL12: limit pulse during motion stops the step; restart needs no clearing.
// RL13: without leave-origin, home return waits until home sensor releases.
// RL14: with leave-origin, home return starts while home sensor is active.
// RL15: Z pulse already high when home activates is skipped.
// RL16: speed is recomputed on every emitted pulse in both ramp shapes.
// RL17: pulser input accepts pulse/dir, plus/minus pulses or quadrature.
// RL18: pre-registers queue the next feed; it starts when current one ends.
// RL19: output is two pulse lines or one pulse line plus direction.
// RL20: start blocked by limit level or latched edge; reset command clears edge.
// RL21: preset start with zero feed emits nothing; may flag stop event.
// RL22: each limit blocks only feed in its own direction.
module mpg_core (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire mpg_pkg::mpg_apb_req_t i_apb,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_limit_pos,
	input wire logic i_limit_neg,
	input wire logic i_home_sensor_input,
	input wire logic i_zphase,
	input wire logic i_encoder_phase_a,
	input wire logic i_encoder_phase_b,
	input wire logic i_pulser_a,
	input wire logic i_pulser_b,
	output logic o_pulse_train_pin,
	output logic o_pulser_sense_pin,
	output logic o_busy
);
	import mpg_pkg::*;

	typedef struct packed {
		mpg_state_t st;
		logic [15:0] mode;
		logic [23:0] feed;
		logic [15:0] start_spd;
		logic [15:0] top_spd;
		logic [15:0] accel;
		logic [15:0] decel;
		logic [31:0] cmp;
		logic [31:0] cnt_cmd;
		logic [31:0] cnt_fb;
		logic [31:0] lat_cmd;
		logic [31:0] lat_fb;
		logic [23:0] pre_feed;
		logic [15:0] pre_top;
		logic pre_valid;
		logic [23:0] remain;
		logic [23:0] ramp_cnt;
		logic [15:0] cur_spd;
		logic [15:0] top_eff;
		logic [15:0] jerk;
		logic [23:0] acc;
		logic step_fwd;
		logic step_rev;
		logic dir_q;
		logic lim_p_q;
		logic lim_n_q;
		logic lim_p_edge;
		logic lim_n_edge;
		logic cmp_hit;
		logic stop_evt;
		logic home_q;
		logic z_q;
		logic z_armed;
		logic home_off_seen;
		logic [7:0] zcnt;
		logic enc_a;
		logic enc_b;
		logic pa;
		logic pb;
		logic [31:0] prdata;
	} mpg_regs_t;

	mpg_regs_t r;
	mpg_regs_t next_r;

	// ************************************************************
	// helpers
	// ************************************************************
	// little-endian lane merge: lane k carries bits 8k+7..8k
	function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int k = 0; k < 4; k++) begin
			if (strb[k]) begin
				res[8*k +: 8] = new_v[8*k +: 8];
			end
		end
		return res;
	endfunction : lane_merge

	// quadrature step: {valid, up}
	function automatic logic [1:0] quad(input logic a0, input logic b0,
		input logic a1, input logic b1);
		logic [1:0] res;
		res = 2'h0;
		if ((a0 ^ a1) ^ (b0 ^ b1)) begin
			res = {1'b1, a0 ^ b1};
		end
		return res;
	endfunction : quad

	// top speed limited so a short feed still reaches a peak, same inputs same result
	function automatic logic [15:0] corr_top(input logic en, input logic [15:0] top,
		input logic [15:0] start, input logic [15:0] acc_r, input logic [23:0] feed);
		logic [31:0] lim;
		lim = {16'h0000, start} + 32'(acc_r) * 32'(feed[16:1]);
		corr_top = (en && lim < {16'h0000, top}) ? lim[15:0] : top;
	endfunction : corr_top

	// ************************************************************
	// next state
	// ************************************************************
	logic wr;
	logic rd_setup;
	logic hit;
	logic [31:0] wv;
	logic [31:0] rv;
	logic [24:0] acc_sum;
	logic lim_dir;
	logic start_ok;
	logic tick;
	logic finish;
	logic z_count;
	logic [1:0] enc_q;
	logic [1:0] pq;
	logic p_ev;
	logic p_up;
	logic [16:0] spd_up;
	logic [15:0] delta;

	always_comb begin
		next_r = r;
		next_r.step_fwd = 1'b0;
		next_r.step_rev = 1'b0;
		wr = i_apb.psel && i_apb.penable && i_apb.pwrite;
		rd_setup = i_apb.psel && !i_apb.penable && !i_apb.pwrite;
		wv = 32'h0000_0000;
		rv = 32'h0000_0000;
		hit = 1'b1;
		acc_sum = 25'h000_0000;
		tick = 1'b0;
		finish = 1'b0;
		z_count = 1'b0;
		p_ev = 1'b0;
		p_up = 1'b0;
		spd_up = 17'h0_0000;
		delta = 16'h0000;
		pq = 2'h0;

		// ********************************************************
		// register read mux
		// ********************************************************
		case (i_apb.paddr)
			`MPG_OFS_CMD: rv = 32'h0000_0000;
			`MPG_OFS_MODE: rv = {16'h0000, r.mode};
			`MPG_OFS_FEED: rv = {8'h00, r.feed};
			`MPG_OFS_START: rv = {16'h0000, r.start_spd};
			`MPG_OFS_TOP: rv = {16'h0000, r.top_spd};
			`MPG_OFS_ACCEL: rv = {16'h0000, r.accel};
			`MPG_OFS_DECEL: rv = {16'h0000, r.decel};
			`MPG_OFS_CMP: rv = r.cmp;
			`MPG_OFS_CNT_CMD: rv = r.cnt_cmd;
			`MPG_OFS_CNT_FB: rv = r.cnt_fb;
			`MPG_OFS_LAT_CMD: rv = r.lat_cmd;
			`MPG_OFS_LAT_FB: rv = r.lat_fb;
			`MPG_OFS_STATUS: rv = {24'h00_0000, r.dir_q, r.lim_n_edge, r.lim_p_edge,
				r.pre_valid, r.stop_evt, r.cmp_hit, r.st == MPG_WAIT, r.st == MPG_RUN};
			`MPG_OFS_PRE_FEED: rv = {8'h00, r.pre_feed};
			`MPG_OFS_PRE_TOP: rv = {16'h0000, r.pre_top};
			`MPG_OFS_TOP_EFF: rv = {16'h0000, r.top_eff};
			`MPG_OFS_ZCNT: rv = {24'h00_0000, r.zcnt};
			default: hit = 1'b0;
		endcase
		if (rd_setup) begin
			next_r.prdata = rv;
		end

		// ********************************************************
		// register writes
		// ********************************************************
		wv = lane_merge(rv, i_apb.pwdata, i_apb.pstrb); // [RL8] [RL7]
		if (wr) begin
			case (i_apb.paddr)
				`MPG_OFS_MODE: next_r.mode = wv[15:0];
				`MPG_OFS_FEED: next_r.feed = wv[23:0];
				`MPG_OFS_START: next_r.start_spd = wv[15:0];
				`MPG_OFS_TOP: next_r.top_spd = wv[15:0];
				`MPG_OFS_ACCEL: next_r.accel = wv[15:0]; // [RL5]
				`MPG_OFS_DECEL: next_r.decel = wv[15:0]; // [RL5]
				`MPG_OFS_CMP: next_r.cmp = wv;
				`MPG_OFS_CNT_CMD: next_r.cnt_cmd = wv;
				`MPG_OFS_CNT_FB: next_r.cnt_fb = wv;
				`MPG_OFS_PRE_TOP: next_r.pre_top = wv[15:0];
				`MPG_OFS_STATUS: begin
					// write one to clear; events below set afterwards and win
					if (i_apb.pstrb[0] && i_apb.pwdata[`MPG_ST_CMP]) next_r.cmp_hit = 1'b0;
					if (i_apb.pstrb[0] && i_apb.pwdata[`MPG_ST_STOPEV]) next_r.stop_evt = 1'b0;
				end
				`MPG_OFS_PRE_FEED: begin
					next_r.pre_feed = wv[23:0];
					next_r.pre_valid = 1'b1; // [RL18]
				end
				default: ;
			endcase
		end

		// ********************************************************
		// limit inputs
		// ********************************************************
		next_r.lim_p_q = i_limit_pos;
		next_r.lim_n_q = i_limit_neg;
		// edges latch only outside motion, so a blip on the limit in the running direction ends the current run only
		if (wr && i_apb.paddr == `MPG_OFS_CMD && wv[`MPG_CMD_RESET]) begin
			next_r.lim_p_edge = 1'b0;
			next_r.lim_n_edge = 1'b0;
		end
		if (r.st != MPG_RUN && i_limit_pos && !r.lim_p_q) next_r.lim_p_edge = 1'b1; // [RL20]
		if (r.st != MPG_RUN && i_limit_neg && !r.lim_n_q) next_r.lim_n_edge = 1'b1; // [RL20]
		lim_dir = r.dir_q ? i_limit_pos : i_limit_neg; // [RL22]
		start_ok = r.mode[`MPG_MODE_DIR] ? !(i_limit_pos || r.lim_p_edge) // [RL20] [RL11]
			: !(i_limit_neg || r.lim_n_edge); // [RL22]

		// ********************************************************
		// encoder and home / Z tracking
		// ********************************************************
		next_r.enc_a = i_encoder_phase_a;
		next_r.enc_b = i_encoder_phase_b;
		enc_q = quad(r.enc_a, r.enc_b, i_encoder_phase_a, i_encoder_phase_b);
		if (enc_q[1]) begin
			next_r.cnt_fb = enc_q[0] ? r.cnt_fb + 32'h0000_0001 : r.cnt_fb - 32'h0000_0001; // [RL2]
		end
		next_r.home_q = i_home_sensor_input;
		next_r.z_q = i_zphase;
		if (!i_zphase) begin
			next_r.z_armed = 1'b1;
		end else if (i_home_sensor_input && !r.home_q) begin
			next_r.z_armed = 1'b0; // [RL15]
		end
		if (!i_home_sensor_input) next_r.home_off_seen = 1'b1;
		z_count = i_zphase && !r.z_q && r.z_armed && i_home_sensor_input
			&& r.home_off_seen; // [RL15]
		if (z_count && r.st == MPG_RUN) next_r.zcnt = r.zcnt + 8'h01;

		// ********************************************************
		// control state machine and rate divider
		// ********************************************************
		case (r.st)
			MPG_IDLE: begin
				next_r.acc = 24'h00_0000;
				if (wr && i_apb.paddr == `MPG_OFS_CMD && wv[`MPG_CMD_START] && start_ok) begin
					next_r.dir_q = r.mode[`MPG_MODE_DIR];
					next_r.cur_spd = r.start_spd;
					next_r.jerk = 16'h0000;
					next_r.ramp_cnt = 24'h00_0000;
					next_r.remain = r.feed;
					next_r.zcnt = 8'h00;
					next_r.top_eff = corr_top(r.mode[`MPG_MODE_CORR], r.top_spd,
						r.start_spd, r.accel, r.feed); // [RL6]
					if (r.mode[`MPG_MODE_PRESET] && r.feed == 24'h00_0000) begin
						if (r.mode[`MPG_MODE_STOPEV]) next_r.stop_evt = 1'b1; // [RL21]
					end else if (r.mode[`MPG_MODE_HOME] && i_home_sensor_input) begin
						if (r.mode[`MPG_MODE_LEAVE]) begin
							next_r.home_off_seen = 1'b0;
							next_r.st = MPG_RUN; // [RL14]
						end else begin
							next_r.st = MPG_WAIT; // [RL13]
						end
					end else begin
						next_r.home_off_seen = 1'b1;
						next_r.st = MPG_RUN;
					end
				end else if (r.mode[`MPG_MODE_PULSER +: 2] != 2'b00) begin
					// manual pulser passes straight through while no feed runs
					next_r.pa = i_pulser_a;
					next_r.pb = i_pulser_b;
					pq = quad(r.pa, r.pb, i_pulser_a, i_pulser_b);
					case (r.mode[`MPG_MODE_PULSER +: 2])
						2'b01: begin
							p_ev = i_pulser_a && !r.pa;
							p_up = i_pulser_b;
						end
						2'b10: begin
							p_ev = (i_pulser_a && !r.pa) ^ (i_pulser_b && !r.pb);
							p_up = i_pulser_a && !r.pa;
						end
						default: begin
							p_ev = pq[1];
							p_up = pq[0];
						end
					endcase
					if (p_ev && !(p_up ? i_limit_pos : i_limit_neg)) begin // [RL17]
						next_r.dir_q = p_up;
						next_r.step_fwd = p_up;
						next_r.step_rev = !p_up;
						next_r.cnt_cmd = r.cnt_cmd + 32'h0000_0001;
					end
				end
			end
			MPG_WAIT: begin
				if (wr && i_apb.paddr == `MPG_OFS_CMD && wv[`MPG_CMD_STOP]) begin
					next_r.st = MPG_IDLE;
				end else if (!i_home_sensor_input) begin
					next_r.st = MPG_RUN; // [RL13]
				end
			end
			MPG_RUN: begin
				acc_sum = {1'b0, r.acc} + {9'h000, r.cur_spd};
				if (lim_dir) begin
					// limit level acts as divider reset, over any command
					next_r.acc = 24'h00_0000; // [RL9]
					next_r.st = MPG_IDLE; // [RL10] [RL12]
				end else if (wr && i_apb.paddr == `MPG_OFS_CMD && wv[`MPG_CMD_STOP]) begin
					next_r.acc = 24'h00_0000;
					next_r.st = MPG_IDLE;
				end else if (r.mode[`MPG_MODE_HOME] && z_count) begin
					finish = 1'b1;
				end else begin
					next_r.acc = acc_sum[23:0];
					tick = acc_sum[24];
				end
				if (tick) begin
					next_r.step_fwd = r.dir_q;
					next_r.step_rev = !r.dir_q;
					next_r.cnt_cmd = r.cnt_cmd + 32'h0000_0001; // [RL1]
					next_r.remain = r.remain - 24'h00_0001;
					// new period on every pulse, never a flat stair
					if (r.mode[`MPG_MODE_SCURVE]) begin
						delta = (r.jerk < r.accel) ? r.jerk + 16'h0001 : r.accel;
					end else begin
						delta = r.accel;
					end
					if (r.mode[`MPG_MODE_PRESET] && r.remain <= r.ramp_cnt + 24'h00_0001) begin
						next_r.cur_spd = ({1'b0, r.cur_spd} >
							{1'b0, r.start_spd} + {1'b0, r.decel})
							? r.cur_spd - r.decel : r.start_spd; // [RL16] [RL5]
					end else if (r.cur_spd < r.top_eff) begin
						spd_up = {1'b0, r.cur_spd} + {1'b0, delta};
						next_r.cur_spd = (spd_up > {1'b0, r.top_eff})
							? r.top_eff : spd_up[15:0]; // [RL16] [RL5]
						next_r.jerk = delta;
						next_r.ramp_cnt = r.ramp_cnt + 24'h00_0001;
					end
					if (r.mode[`MPG_MODE_PRESET] && r.remain == 24'h00_0001) finish = 1'b1;
				end
				if (finish) begin
					next_r.acc = 24'h00_0000;
					if (r.mode[`MPG_MODE_AUTO] && r.pre_valid) begin
						// chained feed keeps current speed and direction
						next_r.remain = r.pre_feed; // [RL18]
						next_r.top_eff = r.pre_top;
						next_r.ramp_cnt = 24'h00_0000;
						next_r.pre_valid = wr && i_apb.paddr == `MPG_OFS_PRE_FEED;
						if (r.pre_feed == 24'h00_0000) next_r.st = MPG_IDLE;
					end else begin
						next_r.st = MPG_IDLE;
						if (r.mode[`MPG_MODE_STOPEV]) next_r.stop_evt = 1'b1;
					end
				end
			end
			default: next_r.st = MPG_IDLE;
		endcase

		// ********************************************************
		// latch and comparator
		// ********************************************************
		if (wr && i_apb.paddr == `MPG_OFS_CMD && wv[`MPG_CMD_LATCH]) begin
			next_r.lat_cmd = r.cnt_cmd; // [RL3]
			next_r.lat_fb = r.cnt_fb; // [RL3]
		end
		if ((r.mode[`MPG_MODE_CMPSRC] ? r.cnt_fb : r.cnt_cmd) == r.cmp) begin
			next_r.cmp_hit = 1'b1; // [RL4]
		end
	end

	// ************************************************************
	// state register
	// ************************************************************
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			r <= '0;
			r.st <= MPG_IDLE;
			r.mode <= `MPG_RST_MODE;
			r.start_spd <= `MPG_RST_START;
			r.top_spd <= `MPG_RST_TOP;
			r.accel <= `MPG_RST_ACCEL;
			r.decel <= `MPG_RST_DECEL;
			r.cmp <= 32'hFFFF_FFFF;
			r.home_off_seen <= 1'b1;
		end else begin
			r <= next_r; // [RL7]
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign o_prdata = r.prdata;
	assign o_pready = 1'b1;
	assign o_pslverr = i_apb.psel && i_apb.penable && !hit;
	// pulse+dir mode puts the direction level on the second pin
	assign o_pulse_train_pin = r.mode[`MPG_MODE_OUTSEL] ? (r.step_fwd | r.step_rev)
		: r.step_fwd; // [RL19]
	assign o_pulser_sense_pin = r.mode[`MPG_MODE_OUTSEL] ? r.dir_q : r.step_rev; // [RL19]
	assign o_busy = r.st != MPG_IDLE;
endmodule : mpg_core
`default_nettype wire

/* include/mpg_cfg.svh */
// motion pulse generator: offsets, field positions and reset values
// assumes: included by the design file, the monitor and the bench, by bare name
`ifndef MPG_CFG_SVH
`define MPG_CFG_SVH
// register byte offsets
`define MPG_OFS_CMD 8'h00
`define MPG_OFS_MODE 8'h04
`define MPG_OFS_FEED 8'h08
`define MPG_OFS_START 8'h0C
`define MPG_OFS_TOP 8'h10
`define MPG_OFS_ACCEL 8'h14
`define MPG_OFS_DECEL 8'h18
`define MPG_OFS_CMP 8'h1C
`define MPG_OFS_CNT_CMD 8'h20
`define MPG_OFS_CNT_FB 8'h24
`define MPG_OFS_LAT_CMD 8'h28
`define MPG_OFS_LAT_FB 8'h2C
`define MPG_OFS_STATUS 8'h30
`define MPG_OFS_PRE_FEED 8'h34
`define MPG_OFS_PRE_TOP 8'h38
`define MPG_OFS_TOP_EFF 8'h3C
`define MPG_OFS_ZCNT 8'h40
// command bits
`define MPG_CMD_START 0
`define MPG_CMD_STOP 1
`define MPG_CMD_RESET 2
`define MPG_CMD_LATCH 3
// mode bits
`define MPG_MODE_DIR 0
`define MPG_MODE_OUTSEL 1
`define MPG_MODE_PRESET 2
`define MPG_MODE_PULSER 3
`define MPG_MODE_HOME 5
`define MPG_MODE_LEAVE 6
`define MPG_MODE_STOPEV 7
`define MPG_MODE_AUTO 8
`define MPG_MODE_CORR 9
`define MPG_MODE_CMPSRC 10
`define MPG_MODE_SCURVE 11
// status bits
`define MPG_ST_RUN 0
`define MPG_ST_WAIT 1
`define MPG_ST_CMP 2
`define MPG_ST_STOPEV 3
`define MPG_ST_PRE 4
`define MPG_ST_LIMP 5
`define MPG_ST_LIMN 6
`define MPG_ST_DIR 7
// reset values
`define MPG_RST_MODE 16'h0005
`define MPG_RST_START 16'h0100
`define MPG_RST_TOP 16'h1000
`define MPG_RST_ACCEL 16'h0010
`define MPG_RST_DECEL 16'h0010
`endif

/* include/mpg_pkg.sv */
// motion pulse generator: shared types
// assumes: mpg_cfg.svh is on the include path
package mpg_pkg;
	typedef enum logic [2:0] {
		MPG_IDLE = 3'b001,
		MPG_WAIT = 3'b010,
		MPG_RUN = 3'b100
	} mpg_state_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
		logic [3:0] pstrb;
	} mpg_apb_req_t;

	typedef struct packed {
		logic prdata_unused;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} mpg_apb_rsp_t;
endpackage : mpg_pkg

/* dv/mpg_core_monitor.sv */
// port checker for the one-axis pulse generator
// assumes: bound to mpg_core; mode bits are snooped from APB writes to lane 0
`timescale 1ns/1ps
`default_nettype none
`include "mpg_cfg.svh"
module mpg_core_monitor (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire mpg_pkg::mpg_apb_req_t i_apb,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic i_limit_pos,
	input wire logic i_limit_neg,
	input wire logic o_pulse_train_pin,
	input wire logic o_pulser_sense_pin,
	input wire logic o_busy
);
	import mpg_pkg::*;
	// ****
	// mode snoop and properties
	// ****
	logic [7:0] mode_lo;
	logic acc;
	logic wr;
	logic rd_setup;
	assign acc = i_apb.psel && i_apb.penable;
	assign wr = acc && i_apb.pwrite && i_apb.pstrb[0];
	assign rd_setup = i_apb.psel && !i_apb.penable && !i_apb.pwrite;
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			mode_lo <= 8'h05;
		end else if (wr && i_apb.paddr == `MPG_OFS_MODE) begin
			mode_lo <= i_apb.pwdata[7:0];
		end
	end
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);
	ready_high_a: assert property (o_pready) else $error("pready low");
	err_phase_a: assert property (o_pslverr |-> acc) else $error("stray pslverr");
	err_unmapped_a: assert property (acc && i_apb.paddr > 8'h40 |-> o_pslverr)
		else $error("unmapped access not refused");
	rdata_hold_a: assert property ($changed(o_prdata) |-> $past(rd_setup))
		else $error("read data moved outside read setup");
	step_width_a: assert property (o_pulse_train_pin |=> !o_pulse_train_pin)
		else $error("step pulse wider than one cycle");
	fwd_limit_a: assert property ((!mode_lo[1] && i_limit_pos)[*3] |-> !o_pulse_train_pin)
		else $error("forward step under positive limit");
	rev_limit_a: assert property ((!mode_lo[1] && i_limit_neg)[*3] |-> !o_pulser_sense_pin)
		else $error("reverse step under negative limit");
	limit_halt_a: assert property ($rose(i_limit_pos) && mode_lo[0] && o_busy |-> ##[1:2] !o_busy)
		else $error("run survives limit");
	stop_cmd_a: assert property (wr && i_apb.paddr == `MPG_OFS_CMD && i_apb.pwdata[1] |-> ##[1:2] !o_busy)
		else $error("stop ignored");
	idle_quiet_a: assert property (!o_busy && !$past(o_busy) && mode_lo[4:3] == 2'h0 |=> !o_pulse_train_pin)
		else $error("step while idle");
endmodule : mpg_core_monitor
bind mpg_core mpg_core_monitor mpg_core_monitor_inst (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
	.i_apb(i_apb), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
	.i_limit_pos(i_limit_pos), .i_limit_neg(i_limit_neg), .o_pulse_train_pin(o_pulse_train_pin),
	.o_pulser_sense_pin(o_pulser_sense_pin), .o_busy(o_busy));
`default_nettype wire

/* dv/mpg_motor_model.sv */
// motor driver with incremental encoder facing the step outputs
// assumes: one step per cycle at most; bench tells it the output mode
`timescale 1ns/1ps
`default_nettype none
module mpg_motor_model (
	input wire logic i_clk,
	input wire logic i_pulse_dir_mode,
	input wire logic i_slow,
	input wire logic i_step_line,
	input wire logic i_sense_line,
	output logic o_phase_a,
	output logic o_phase_b
);
	// ****
	// shaft position to quadrature
	// ****
	logic [1:0] pos = 2'h0;
	logic [15:0] hist = 16'h0;
	logic [1:0] shown;
	always @(posedge i_clk) begin
		if (i_step_line) begin
			pos <= (i_pulse_dir_mode && !i_sense_line) ? pos - 2'h1 : pos + 2'h1;
		end else if (!i_pulse_dir_mode && i_sense_line) begin
			pos <= pos - 2'h1;
		end
		hist <= {hist[13:0], pos};
	end
	// a slow shaft shows its motion eight cycles late
	assign shown = i_slow ? hist[15:14] : pos;
	assign o_phase_a = shown[1];
	assign o_phase_b = shown[1] ^ shown[0];
endmodule : mpg_motor_model
`default_nettype wire

/* dv/mpg_core_tb_top.sv */
// self-checking bench for the one-axis pulse generator
// assumes: 125 MHz clock, pready answer from the design, speeds set near maximum
`timescale 1ns/1ps
`default_nettype none
`include "mpg_cfg.svh"
module mpg_core_tb_top;
	import mpg_pkg::*;
	// ****
	// harness
	// ****
	logic clk = 1'b0;
	logic rstn = 1'b0;
	mpg_apb_req_t req = '0;
	logic [31:0] prdata;
	logic pready, pslverr, step, sense, busy, enc_a, enc_b, last_err;
	logic lim_p = 1'b0;
	logic lim_n = 1'b0;
	logic zp = 1'b0;
	logic home = 1'b0;
	logic pa = 1'b0;
	logic pb = 1'b0;
	logic pd = 1'b0;
	logic slow = 1'b0;
	int err_total = 0;
	int n_compared = 0;
	int nf = 0;
	int nr = 0;
	logic [39:0] rst_tab [8] = '{40'h04_00000005, 40'h0C_00000100, 40'h10_00001000,
		40'h14_00000010, 40'h18_00000010, 40'h1C_FFFFFFFF, 40'h20_00000000, 40'h24_00000000};
	mpg_core mpg_core_inst (.i_sys_clk(clk), .i_resetn(rstn), .i_apb(req), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_limit_pos(lim_p), .i_limit_neg(lim_n),
		.i_home_sensor_input(home), .i_zphase(zp), .i_encoder_phase_a(enc_a),
		.i_encoder_phase_b(enc_b), .i_pulser_a(pa), .i_pulser_b(pb), .o_pulse_train_pin(step),
		.o_pulser_sense_pin(sense), .o_busy(busy));
	mpg_motor_model mpg_motor_model_inst (.i_clk(clk), .i_pulse_dir_mode(pd), .i_slow(slow),
		.i_step_line(step), .i_sense_line(sense), .o_phase_a(enc_a), .o_phase_b(enc_b));
	initial begin
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		if (step === 1'b1) nf++;
		if (sense === 1'b1 && !pd) nr++;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] q);
		@(posedge clk);
		req <= '{1'b1, 1'b0, w, a, d, s};
		@(posedge clk);
		req.penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		last_err = pslverr;
		req <= '0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, 4'hF, q);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		apb(1'b0, a, 32'h0, 4'h0, q);
	endtask : rd
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		rd(a, q);
		check(q, e);
	endtask : rd_chk
	task automatic go(input logic [31:0] m, input logic [31:0] f);
		wr(`MPG_OFS_MODE, m);
		pd <= m[1];
		wr(`MPG_OFS_FEED, f);
		wr(`MPG_OFS_CMD, 32'h1);
	endtask : go
	task automatic idle_wait();
		int n;
		n = 0;
		repeat (3) @(negedge clk);
		while (busy !== 1'b0 && n < 20000) begin
			@(negedge clk);
			n++;
		end
		if (n >= 20000) err_total++;
		repeat (4) @(negedge clk);
	endtask : idle_wait
	task automatic pls(input logic [1:0] v);
		@(posedge clk);
		{pb, pa} <= v;
		repeat (6) @(posedge clk);
	endtask : pls
	task automatic results();
		$display("compared=%0d mismatches=%0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results
	initial begin
		repeat (60000) @(posedge clk);
		err_total++;
		results();
	end
	// ****
	// scenarios
	// ****
	initial begin
		logic [31:0] q, r;
		int s;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		foreach (rst_tab[i]) rd_chk(rst_tab[i][39:32], rst_tab[i][31:0]);
		go(32'h205, 32'h4);
		wr(`MPG_OFS_CMD, 32'h2);
		rd_chk(`MPG_OFS_TOP_EFF, 32'h120);
		rd_chk(`MPG_OFS_TOP_EFF, 32'h120);
		wr(`MPG_OFS_ACCEL, 32'h33);
		rd_chk(`MPG_OFS_DECEL, 32'h10);
		rd_chk(`MPG_OFS_ACCEL, 32'h33);
		apb(1'b1, `MPG_OFS_CMP, 32'h5A5A5AA5, 4'h1, q);
		rd_chk(`MPG_OFS_CMP, 32'hFFFFFFA5);
		rd_chk(8'h80, 32'h0);
		check(last_err, 32'h1);
		wr(`MPG_OFS_START, 32'hFFFF);
		wr(`MPG_OFS_TOP, 32'hFFFF);
		wr(`MPG_OFS_PRE_TOP, 32'hFFFF);
		wr(`MPG_OFS_CMP, 32'h2);
		go(32'h5, 32'h3);
		idle_wait();
		check(nf, 3);
		check(nr, 0);
		rd_chk(`MPG_OFS_CNT_CMD, 32'h3);
		rd(`MPG_OFS_CNT_FB, q);
		check(q == 32'h3 || q == 32'hFFFFFFFD, 32'h1);
		rd(`MPG_OFS_STATUS, q);
		check(q[2], 32'h1);
		wr(`MPG_OFS_STATUS, 32'h4);
		rd(`MPG_OFS_STATUS, q);
		check(q[2], 32'h0);
		slow <= 1'b1;
		go(32'h4, 32'h3);
		idle_wait();
		repeat (12) @(posedge clk);
		check(nr, 3);
		rd_chk(`MPG_OFS_CNT_CMD, 32'h6);
		rd_chk(`MPG_OFS_CNT_FB, 32'h0);
		slow <= 1'b0;
		wr(`MPG_OFS_CNT_CMD, 32'h0);
		go(32'h5, 32'h8);
		repeat (700) @(posedge clk);
		wr(`MPG_OFS_CMD, 32'h8);
		@(negedge clk);
		check(busy, 32'h1);
		rd(`MPG_OFS_LAT_CMD, q);
		rd(`MPG_OFS_LAT_FB, r);
		check(r == q || r == -q, 32'h1);
		check(q > 1 && q < 5, 32'h1);
		idle_wait();
		check(nf, 11);
		go(32'h85, 32'h0);
		repeat (20) @(negedge clk);
		check(busy, 32'h0);
		rd(`MPG_OFS_STATUS, q);
		check(q[3], 32'h1);
		go(32'h6, 32'h2);
		idle_wait();
		check(sense, 32'h0);
		go(32'h7, 32'h1);
		idle_wait();
		check(sense, 32'h1);
		check(nf, 14);
		@(posedge clk);
		lim_p <= 1'b1;
		go(32'h5, 32'h2);
		repeat (600) @(posedge clk);
		check(nf, 14);
		go(32'h4, 32'h2);
		idle_wait();
		check(nr, 5);
		@(posedge clk);
		lim_p <= 1'b0;
		go(32'h5, 32'h1);
		repeat (600) @(posedge clk);
		check(nf, 14);
		wr(`MPG_OFS_CMD, 32'h4);
		go(32'h5, 32'h1);
		idle_wait();
		check(nf, 15);
		go(32'h5, 32'h8);
		repeat (400) @(posedge clk);
		lim_p <= 1'b1;
		@(posedge clk);
		lim_p <= 1'b0;
		repeat (4) @(negedge clk);
		check(busy, 32'h0);
		go(32'h5, 32'h1);
		idle_wait();
		check(nf, 17);
		wr(`MPG_OFS_PRE_FEED, 32'h2);
		rd(`MPG_OFS_STATUS, q);
		check(q[4], 32'h1);
		go(32'h105, 32'h2);
		idle_wait();
		idle_wait();
		check(nf, 21);
		wr(`MPG_OFS_MODE, 32'h10);
		pls(2'h1);
		pls(2'h0);
		pls(2'h2);
		pls(2'h0);
		check(nf, 22);
		check(nr, 6);
		wr(`MPG_OFS_MODE, 32'h08);
		pls(2'h2);
		pls(2'h3);
		pls(2'h2);
		pls(2'h0);
		check(nf + nr, 29);
		wr(`MPG_OFS_MODE, 32'h18);
		pls(2'h1);
		pls(2'h3);
		pls(2'h2);
		pls(2'h0);
		check(nf + nr > 29, 32'h1);
		lim_n <= 1'b1;
		s = nr;
		go(32'h4, 32'h1);
		repeat (600) @(posedge clk);
		check(nr, s);
		go(32'h5, 32'h1);
		idle_wait();
		check(nf, 24);
		@(posedge clk);
		lim_n <= 1'b0;
		wr(`MPG_OFS_CMD, 32'h4);
		s = nf;
		home <= 1'b1;
		go(32'h25, 32'h10);
		repeat (600) @(posedge clk);
		rd(`MPG_OFS_STATUS, q);
		check(q[1:0], 32'h2);
		check(nf, s);
		home <= 1'b0;
		repeat (600) @(posedge clk);
		check(nf > s, 32'h1);
		zp <= 1'b1;
		@(posedge clk);
		home <= 1'b1;
		repeat (4) @(posedge clk);
		zp <= 1'b0;
		repeat (4) @(negedge clk);
		check(busy, 32'h1);
		@(posedge clk);
		zp <= 1'b1;
		repeat (4) @(negedge clk);
		check(busy, 32'h0);
		rd_chk(`MPG_OFS_ZCNT, 32'h1);
		zp <= 1'b0;
		wr(`MPG_OFS_CMD, 32'h2);
		home <= 1'b1;
		go(32'h65, 32'h10);
		repeat (10) @(posedge clk);
		rd(`MPG_OFS_STATUS, q);
		check(q[0], 32'h1);
		wr(`MPG_OFS_CMD, 32'h2);
		results();
	end
endmodule : mpg_core_tb_top
`default_nettype wire
